// ==== bench/motion_model.sv ====
// Purpose: Motor, profiler and switch model on a straight axis.
// Assumes: Fast moves 4 counts a cycle, slow 1; the motor coasts DECEL cycles after run falls.
// Notes: Switch levels follow position, so decel overshoot is seen as on a real axis.
`timescale 1ns/1ps
module motion_model #(
    parameter int DECEL = 3
) (
    // Clock
    input wire logic clk,
    // Bench control
    input wire logic load,
    input wire logic [home_pkg::POS_W-1:0] load_pos,
    input wire logic no_home,
    // Profiler commands
    input wire logic motor_run,
    input wire logic motor_forward,
    input wire logic motor_fast,
    // Axis state
    output logic motor_stopped,
    output logic [home_pkg::POS_W-1:0] position,
    output logic home_switch,
    output logic forward_limit_switch,
    output logic reverse_limit_switch
);
    int coast = 0;
    logic dir_ff = 1'b0;
    logic fast_ff = 1'b0;
    wire logic cur_dir = motor_run ? motor_forward : dir_ff;
    wire logic cur_fast = motor_run ? motor_fast : fast_ff;
    wire logic [home_pkg::POS_W-1:0] step = cur_fast ? 32'h0000_0004 : 32'h0000_0001;

    always @(posedge clk) begin
        if (load) begin
            position <= load_pos;
            coast <= 0;
        end else if (motor_run || coast != 0) begin
            position <= cur_dir ? position + step : position - step;
            coast <= motor_run ? DECEL : coast - 1;
            dir_ff <= cur_dir;
            fast_ff <= cur_fast;
        end
    end

    // Standstill is reported only once the coast has ended, so a stop is never early.
    assign motor_stopped = !motor_run && coast == 0;
    assign home_switch = !no_home && position >= 32'h0000_07D0 && position <= 32'h0000_0834;
    assign forward_limit_switch = position >= 32'h0000_0BB8;
    assign reverse_limit_switch = position <= 32'h0000_0064;
endmodule

// ==== bench/servo_homing_modes_20_25_tb.sv ====
// Purpose: Self-checking bench for the homing sequencer, methods 20 to 25.
// Assumes: Home region 2000..2100, forward limit from 3000, reverse limit up to 100.
// Notes: Home is judged by a window beside the expected edge, wide enough for decel overshoot.
`timescale 1ns/1ps
module servo_homing_modes_20_25_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    logic [7:0] method = 8'h00;
    logic load = 1'b1;
    logic [31:0] load_pos = 32'h0000_03E8;
    logic no_home = 1'b0;
    logic motor_stopped, home_switch, forward_limit_switch, reverse_limit_switch;
    logic motor_run, motor_forward, motor_fast;
    logic homing_busy, homing_done, homing_alarm;
    logic [31:0] position, home_position;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    homing_seq dut (.clk(clk), .reset(reset), .start(start), .method(method), .home_switch(home_switch),
        .forward_limit_switch(forward_limit_switch), .reverse_limit_switch(reverse_limit_switch),
        .motor_stopped(motor_stopped), .position(position), .motor_run(motor_run),
        .motor_forward(motor_forward), .motor_fast(motor_fast), .homing_busy(homing_busy),
        .homing_done(homing_done), .homing_alarm(homing_alarm), .home_position(home_position));

    motion_model axis (.clk(clk), .load(load), .load_pos(load_pos), .no_home(no_home),
        .motor_run(motor_run), .motor_forward(motor_forward), .motor_fast(motor_fast),
        .motor_stopped(motor_stopped), .position(position), .home_switch(home_switch),
        .forward_limit_switch(forward_limit_switch), .reverse_limit_switch(reverse_limit_switch));

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    // Places the axis, starts a method and waits for done or alarm.
    task automatic run_case(input logic [7:0] m, input logic [31:0] p0, input logic [31:0] lo,
        input logic [31:0] hi, input logic exp_alarm, input logic nh, input logic [2:0] mot);
        int n;
        n = 0;
        load = 1'b1;
        load_pos = p0;
        no_home = nh;
        @(posedge clk);
        #2 load = 1'b0;
        repeat (4) @(posedge clk);
        #2 start = 1'b1;
        method = m;
        @(posedge clk);
        #2 start = 1'b0;
        // First command after the start: run, direction and speed, masked while not running.
        chk({29'h0, motor_run, motor_run && motor_forward, motor_run && motor_fast}, {29'h0, mot});
        while (homing_done !== 1'b1 && homing_alarm !== 1'b1 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        #2;
        chk({31'h0, homing_alarm}, {31'h0, exp_alarm});
        chk({31'h0, homing_done}, {31'h0, !exp_alarm});
        chk({31'h0, homing_busy}, 32'h0000_0000);
        chk({31'h0, motor_run}, 32'h0000_0000);
        if (!exp_alarm) begin
            chk(home_position, position);
            chk({31'h0, home_position >= lo && home_position <= hi}, 32'h0000_0001);
        end
    endtask

    task automatic t_m20();
        run_case(home_pkg::METHOD_20, 32'h0000_03E8, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_20, 32'h0000_0802, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h4);
        $display("test method 20 done");
    endtask

    task automatic t_m21();
        run_case(home_pkg::METHOD_21, 32'h0000_09C4, 32'h0000_0835, 32'h0000_0845, 1'b0, 1'b0, 3'h5);
        run_case(home_pkg::METHOD_21, 32'h0000_0802, 32'h0000_0835, 32'h0000_0845, 1'b0, 1'b0, 3'h6);
        $display("test method 21 done");
    endtask

    task automatic t_m22();
        run_case(home_pkg::METHOD_22, 32'h0000_09C4, 32'h0000_0824, 32'h0000_0834, 1'b0, 1'b0, 3'h5);
        run_case(home_pkg::METHOD_22, 32'h0000_0802, 32'h0000_0824, 32'h0000_0834, 1'b0, 1'b0, 3'h6);
        $display("test method 22 done");
    endtask

    task automatic t_m23();
        run_case(home_pkg::METHOD_23, 32'h0000_09C4, 32'h0000_07BF, 32'h0000_07CF, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_23, 32'h0000_03E8, 32'h0000_07BF, 32'h0000_07CF, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_23, 32'h0000_0802, 32'h0000_07BF, 32'h0000_07CF, 1'b0, 1'b0, 3'h4);
        $display("test method 23 done");
    endtask

    task automatic t_m24();
        run_case(home_pkg::METHOD_24, 32'h0000_09C4, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_24, 32'h0000_03E8, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_24, 32'h0000_0802, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h4);
        $display("test method 24 done");
    endtask

    task automatic t_m25();
        run_case(home_pkg::METHOD_25, 32'h0000_09C4, 32'h0000_0824, 32'h0000_0834, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_25, 32'h0000_03E8, 32'h0000_0824, 32'h0000_0834, 1'b0, 1'b0, 3'h7);
        run_case(home_pkg::METHOD_25, 32'h0000_0802, 32'h0000_0824, 32'h0000_0834, 1'b0, 1'b0, 3'h6);
        $display("test method 25 done");
    endtask

    // A missing home switch drives 23 and 24 through the reversal into the reverse limit.
    task automatic t_limits();
        run_case(home_pkg::METHOD_20, 32'h0000_0BEA, 32'h0, 32'h0, 1'b1, 1'b0, 3'h0);
        run_case(home_pkg::METHOD_21, 32'h0000_03E8, 32'h0, 32'h0, 1'b1, 1'b0, 3'h5);
        run_case(home_pkg::METHOD_22, 32'h0000_0032, 32'h0, 32'h0, 1'b1, 1'b0, 3'h0);
        run_case(home_pkg::METHOD_23, 32'h0000_09C4, 32'h0, 32'h0, 1'b1, 1'b1, 3'h7);
        run_case(home_pkg::METHOD_24, 32'h0000_03E8, 32'h0, 32'h0, 1'b1, 1'b1, 3'h7);
        $display("test limits done");
    endtask

    // An unsupported code must leave the previous done status untouched.
    task automatic t_refuse();
        run_case(home_pkg::METHOD_20, 32'h0000_03E8, 32'h0000_07D0, 32'h0000_07E0, 1'b0, 1'b0, 3'h7);
        #2 start = 1'b1;
        method = 8'h1A;
        @(posedge clk);
        #2 start = 1'b0;
        repeat (5) @(posedge clk);
        #2;
        chk({31'h0, homing_busy}, 32'h0000_0000);
        chk({31'h0, homing_done}, 32'h0000_0001);
        $display("test refuse done");
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 80000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        #2 reset = 1'b0;
        t_m20();
        t_m21();
        t_m22();
        t_m23();
        t_m24();
        t_m25();
        t_limits();
        t_refuse();
        end_sim();
    end
endmodule

// ==== core/home_pkg.sv ====
// Purpose: Shared constants and types for the homing sequencer.
// Assumes: Method numbers are presented as an 8-bit code.
// Notes: Step indices address the per-method step table in homing_seq.
package home_pkg;
    localparam int METHOD_W = 8;
    localparam int POS_W = 32;
    localparam int STEP_W = 3;
    localparam int SW_COUNT = 3;

    // Supported homing methods.
    localparam logic [METHOD_W-1:0] METHOD_20 = 8'h14;
    localparam logic [METHOD_W-1:0] METHOD_21 = 8'h15;
    localparam logic [METHOD_W-1:0] METHOD_22 = 8'h16;
    localparam logic [METHOD_W-1:0] METHOD_23 = 8'h17;
    localparam logic [METHOD_W-1:0] METHOD_24 = 8'h18;
    localparam logic [METHOD_W-1:0] METHOD_25 = 8'h19;

    // Entry steps and the step taken after a forward limit reversal.
    localparam logic [STEP_W-1:0] STEP_INACTIVE = 3'h0;
    localparam logic [STEP_W-1:0] STEP_ACTIVE = 3'h1;
    localparam logic [STEP_W-1:0] STEP_LIMIT_23 = 3'h2;
    localparam logic [STEP_W-1:0] STEP_LIMIT_24_25 = 3'h3;

    // Switch slot positions inside the synchroniser vectors.
    localparam int SW_HOME = 0;
    localparam int SW_FWD = 1;
    localparam int SW_REV = 2;

    localparam logic [POS_W-1:0] HOME_POS_RESET = 32'h0000_0000;

    // One motion step: direction, speed, edge that ends it, whether the
    // motor stops there, whether that stop is home, and the following step.
    typedef struct packed {
        logic fwd;
        logic fast;
        logic rise;
        logic stop;
        logic home;
        logic [STEP_W-1:0] next;
    } step_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_STOP_WAIT
    } state_t;
endpackage

// ==== core/homing_seq.sv ====
// Purpose: Homing sequencer for methods 20 to 25 of a servo drive.
// Assumes: The profiler ramps speed itself and raises motor_stopped at standstill.
// Notes: Other method codes are ignored; limits abort or reverse per method.
`timescale 1ns/1ps
// Summary of operation
// - Method 20 inactive: fast forward, back off, creep rise.
// - Methods 20-22 abort with alarm on any limit.
// - Method 21 inactive: fast reverse, rise, creep forward fall.
// - Method 21 active: creep forward, home on fall.
// - Method 22 inactive: fast reverse, back off, creep rise.
// - Method 22 active: creep forward fall, creep reverse rise.
// - Methods 23-25: first forward limit reverses, else alarm.
// - Method 23 forward side: limit, reverse, refine falling edge.
// - Method 23 reverse side: fast forward, creep reverse fall.
// - Method 23 active: creep reverse, home on fall.
// - Method 24 forward side: limit, reverse, creep forward rise.
// - Method 24 reverse side: fast forward, back off, creep rise.
// - Method 24 active: creep reverse fall, creep forward rise.
// - Method 25 forward side: limit, reverse, back off, creep.
// - Method 25 reverse side: slow on rise, reverse creep.
// - Method 25 active: creep forward fall, creep reverse rise.
module homing_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Mode selection
    input wire logic start,
    input wire logic [home_pkg::METHOD_W-1:0] method,
    // Switches
    input wire logic home_switch,
    input wire logic forward_limit_switch,
    input wire logic reverse_limit_switch,
    // Motion profiler
    input wire logic motor_stopped,
    input wire logic [home_pkg::POS_W-1:0] position,
    output logic motor_run,
    output logic motor_forward,
    output logic motor_fast,
    // Status
    output logic homing_busy,
    output logic homing_done,
    output logic homing_alarm,
    output logic [home_pkg::POS_W-1:0] home_position
);
    switch_if sw ();

    switch_sync u_sync (
        .clk(clk),
        .reset(reset),
        .home_switch(home_switch),
        .forward_limit_switch(forward_limit_switch),
        .reverse_limit_switch(reverse_limit_switch),
        .sw(sw)
    );

    function automatic home_pkg::step_t mk(input logic fwd, input logic fast, input logic rise,
                                           input logic stop, input logic home,
                                           input logic [home_pkg::STEP_W-1:0] next);
        home_pkg::step_t s;
        s.fwd = fwd;
        s.fast = fast;
        s.rise = rise;
        s.stop = stop;
        s.home = home;
        s.next = next;
        return s;
    endfunction

    // Step table. An active home switch at start enters at step 1, which in
    // every method is also where the inactive path continues after step 0.
    function automatic home_pkg::step_t step_of(input logic [home_pkg::METHOD_W-1:0] m,
                                                input logic [home_pkg::STEP_W-1:0] i);
        home_pkg::step_t s;
        s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        case (m)
            home_pkg::METHOD_20, home_pkg::METHOD_24: begin
                case (i)
                    3'h0: s = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1);
                    3'h1: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
                    3'h2: s = mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
                    3'h3: s = mk(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
                    default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
                endcase
            end
            home_pkg::METHOD_21: begin
                case (i)
                    3'h0: s = mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1);
                    3'h1: s = mk(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
                    default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
                endcase
            end
            home_pkg::METHOD_22: begin
                case (i)
                    3'h0: s = mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1);
                    3'h1: s = mk(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
                    3'h2: s = mk(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
                    default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
                endcase
            end
            home_pkg::METHOD_23: begin
                case (i)
                    3'h0: s = mk(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1);
                    3'h1: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
                    3'h2: s = mk(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 3'h3);
                    3'h3: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h4);
                    3'h4: s = mk(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h1);
                    default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
                endcase
            end
            home_pkg::METHOD_25: begin
                case (i)
                    3'h0: s = mk(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h1);
                    3'h1: s = mk(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h2);
                    3'h2: s = mk(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 3'h0);
                    3'h3: s = mk(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1);
                    default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
                endcase
            end
            default: s = mk(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        endcase
        return s;
    endfunction

    function automatic logic is_valid(input logic [home_pkg::METHOD_W-1:0] m);
        return (m >= home_pkg::METHOD_20) && (m <= home_pkg::METHOD_25);
    endfunction

    function automatic logic turns_at_limit(input logic [home_pkg::METHOD_W-1:0] m);
        return m >= home_pkg::METHOD_23;
    endfunction

    home_pkg::state_t state_ff;
    logic [home_pkg::METHOD_W-1:0] method_ff;
    logic [home_pkg::STEP_W-1:0] step_ff;
    logic [home_pkg::STEP_W-1:0] pend_step_ff;
    logic pend_home_ff;
    logic limit_used_ff;
    logic run_ff;
    logic fwd_ff;
    logic fast_ff;
    logic busy_ff;
    logic done_ff;
    logic alarm_ff;
    logic [home_pkg::POS_W-1:0] home_pos_ff;

    home_pkg::step_t cur;
    home_pkg::step_t after_cont;
    home_pkg::step_t after_stop;
    home_pkg::step_t entry;
    wire logic [home_pkg::STEP_W-1:0] entry_idx;
    wire logic accept;
    wire logic start_abort;
    wire logic step_event;
    wire logic limit_mode;
    wire logic abort;
    wire logic reverse;
    wire logic [home_pkg::STEP_W-1:0] limit_step;

    assign entry_idx = sw.home_lvl ? home_pkg::STEP_ACTIVE : home_pkg::STEP_INACTIVE;
    assign entry = step_of(method, entry_idx);
    assign cur = step_of(method_ff, step_ff);
    assign after_cont = step_of(method_ff, cur.next);
    assign after_stop = step_of(method_ff, pend_step_ff);
    assign accept = (state_ff == home_pkg::ST_IDLE) && start && is_valid(method);
    // A limit already on at start of methods 20 to 22 can never be left safely.
    assign start_abort = !turns_at_limit(method) && (sw.fwd_lvl || sw.rev_lvl);
    assign step_event = cur.rise ? sw.home_rise : sw.home_fall;
    assign limit_mode = turns_at_limit(method_ff);
    // Limits are level-checked for methods 20 to 22; for 23 to 25 only fresh
    // activations count, so a limit still held after the reversal is no fault.
    assign abort = busy_ff && (limit_mode ? (sw.rev_rise || (sw.fwd_rise && (limit_used_ff || !fwd_ff)))
                                          : (sw.fwd_lvl || sw.rev_lvl));
    assign reverse = busy_ff && limit_mode && sw.fwd_rise && !limit_used_ff && fwd_ff;
    assign limit_step = (method_ff == home_pkg::METHOD_23) ? home_pkg::STEP_LIMIT_23
                                                           : home_pkg::STEP_LIMIT_24_25;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= home_pkg::ST_IDLE;
            method_ff <= '0;
            step_ff <= '0;
            pend_step_ff <= '0;
            pend_home_ff <= 1'b0;
            limit_used_ff <= 1'b0;
            run_ff <= 1'b0;
            fwd_ff <= 1'b0;
            fast_ff <= 1'b0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            alarm_ff <= 1'b0;
            home_pos_ff <= home_pkg::HOME_POS_RESET;
        end else begin
            case (state_ff)
                home_pkg::ST_IDLE: begin
                    if (accept) begin
                        method_ff <= method;
                        done_ff <= 1'b0;
                        limit_used_ff <= 1'b0;
                        if (start_abort) begin
                            alarm_ff <= 1'b1;
                        end else begin
                            alarm_ff <= 1'b0;
                            busy_ff <= 1'b1;
                            step_ff <= entry_idx;
                            run_ff <= 1'b1;
                            fwd_ff <= entry.fwd;
                            fast_ff <= entry.fast;
                            state_ff <= home_pkg::ST_RUN;
                        end
                    end
                end
                home_pkg::ST_RUN: begin
                    if (abort) begin
                        run_ff <= 1'b0;
                        busy_ff <= 1'b0;
                        alarm_ff <= 1'b1;
                        state_ff <= home_pkg::ST_IDLE;
                    end else if (reverse) begin
                        run_ff <= 1'b0;
                        limit_used_ff <= 1'b1;
                        pend_step_ff <= limit_step;
                        pend_home_ff <= 1'b0;
                        state_ff <= home_pkg::ST_STOP_WAIT;
                    end else if (step_event && cur.stop) begin
                        run_ff <= 1'b0;
                        pend_step_ff <= cur.next;
                        pend_home_ff <= cur.home;
                        state_ff <= home_pkg::ST_STOP_WAIT;
                    end else if (step_event) begin
                        // Slow down without stopping; the profiler owns the ramp.
                        step_ff <= cur.next;
                        fwd_ff <= after_cont.fwd;
                        fast_ff <= after_cont.fast;
                    end
                end
                home_pkg::ST_STOP_WAIT: begin
                    if (abort) begin
                        busy_ff <= 1'b0;
                        alarm_ff <= 1'b1;
                        state_ff <= home_pkg::ST_IDLE;
                    end else if (motor_stopped && pend_home_ff) begin
                        home_pos_ff <= position;
                        done_ff <= 1'b1;
                        busy_ff <= 1'b0;
                        state_ff <= home_pkg::ST_IDLE;
                    end else if (motor_stopped) begin
                        step_ff <= pend_step_ff;
                        run_ff <= 1'b1;
                        fwd_ff <= after_stop.fwd;
                        fast_ff <= after_stop.fast;
                        state_ff <= home_pkg::ST_RUN;
                    end
                end
                default: state_ff <= home_pkg::ST_IDLE;
            endcase
        end
    end

    assign motor_run = run_ff;
    assign motor_forward = fwd_ff;
    assign motor_fast = fast_ff;
    assign homing_busy = busy_ff;
    assign homing_done = done_ff;
    assign homing_alarm = alarm_ff;
    assign home_position = home_pos_ff;

    property p_limit_abort;
        @(posedge clk) disable iff (reset)
        busy_ff && !limit_mode && (sw.fwd_lvl || sw.rev_lvl) |=> alarm_ff && !busy_ff && !run_ff;
    endproperty
    a_limit_abort: assert property (p_limit_abort)
        else $error("Limit during methods 20 to 22 did not abort with alarm.");

    property p_rev_limit_abort;
        @(posedge clk) disable iff (reset)
        busy_ff && limit_mode && sw.rev_rise |=> alarm_ff && !busy_ff;
    endproperty
    a_rev_limit_abort: assert property (p_rev_limit_abort)
        else $error("Reverse limit did not abort methods 23 to 25.");

    property p_second_fwd_limit;
        @(posedge clk) disable iff (reset)
        busy_ff && limit_mode && limit_used_ff && sw.fwd_rise |=> alarm_ff && !run_ff;
    endproperty
    a_second_fwd_limit: assert property (p_second_fwd_limit)
        else $error("Second forward limit did not raise the alarm.");

    property p_first_fwd_limit;
        @(posedge clk) disable iff (reset)
        reverse |=> !run_ff && !alarm_ff && limit_used_ff && busy_ff;
    endproperty
    a_first_fwd_limit: assert property (p_first_fwd_limit)
        else $error("First forward limit did not stop for reversal.");

    property p_done_latch;
        @(posedge clk) disable iff (reset)
        $rose(done_ff) |-> home_pos_ff == $past(position) && $past(motor_stopped) && !run_ff && !alarm_ff;
    endproperty
    a_done_latch: assert property (p_done_latch)
        else $error("Home position not latched from the stop position.");

    property p_stop_on_edge;
        @(posedge clk) disable iff (reset)
        state_ff == home_pkg::ST_RUN && step_event && cur.stop && !abort && !reverse
        |=> !run_ff ##0 state_ff == home_pkg::ST_STOP_WAIT;
    endproperty
    a_stop_on_edge: assert property (p_stop_on_edge)
        else $error("Motor not stopped on the terminating switch edge.");

    property p_active_start;
        @(posedge clk) disable iff (reset)
        accept && !start_abort && sw.home_lvl
        |=> run_ff && !fast_ff && (fwd_ff == ($past(method) == home_pkg::METHOD_21 ||
            $past(method) == home_pkg::METHOD_22 || $past(method) == home_pkg::METHOD_25));
    endproperty
    a_active_start: assert property (p_active_start)
        else $error("Active-start creep has wrong speed or direction.");

    property p_inactive_start;
        @(posedge clk) disable iff (reset)
        accept && !start_abort && !sw.home_lvl
        |=> run_ff && fast_ff && (fwd_ff == !($past(method) == home_pkg::METHOD_21 ||
            $past(method) == home_pkg::METHOD_22));
    endproperty
    a_inactive_start: assert property (p_inactive_start)
        else $error("Inactive-start run has wrong speed or direction.");

    property p_no_run_idle;
        @(posedge clk) disable iff (reset)
        state_ff == home_pkg::ST_IDLE |-> !run_ff && !busy_ff;
    endproperty
    a_no_run_idle: assert property (p_no_run_idle)
        else $error("Motor commanded while sequencer idle.");
endmodule

// ==== core/switch_if.sv ====
// Purpose: Carries synchronised switch levels and their edges.
// Assumes: Driven by switch_sync, read by homing_seq.
// Notes: All edges are one-cycle pulses.
`timescale 1ns/1ps
interface switch_if;
    logic home_lvl;
    logic home_rise;
    logic home_fall;
    logic fwd_lvl;
    logic fwd_rise;
    logic rev_lvl;
    logic rev_rise;

    modport src (
        output home_lvl, home_rise, home_fall, fwd_lvl, fwd_rise, rev_lvl, rev_rise
    );
    modport dst (
        input home_lvl, home_rise, home_fall, fwd_lvl, fwd_rise, rev_lvl, rev_rise
    );
endinterface

// ==== core/switch_sync.sv ====
// Purpose: Two-stage synchroniser and edge detector for the three switches.
// Assumes: Switch inputs are active high.
// Notes: Edges are taken between the second and third stage only.
`timescale 1ns/1ps
module switch_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Raw switches
    input wire logic home_switch,
    input wire logic forward_limit_switch,
    input wire logic reverse_limit_switch,
    // Conditioned switches
    switch_if.src sw
);
    logic [home_pkg::SW_COUNT-1:0] meta_ff;
    logic [home_pkg::SW_COUNT-1:0] lvl_ff;
    logic [home_pkg::SW_COUNT-1:0] prev_ff;
    logic [home_pkg::SW_COUNT-1:0] raw;
    logic [home_pkg::SW_COUNT-1:0] rise;
    logic [home_pkg::SW_COUNT-1:0] fall;

    assign raw = {reverse_limit_switch, forward_limit_switch, home_switch};

    // The first stage is read only by the second stage.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_ff <= '0;
            lvl_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= raw;
            lvl_ff <= meta_ff;
            prev_ff <= lvl_ff;
        end
    end

    assign rise = lvl_ff & ~prev_ff;
    assign fall = ~lvl_ff & prev_ff;

    assign sw.home_lvl = lvl_ff[home_pkg::SW_HOME];
    assign sw.home_rise = rise[home_pkg::SW_HOME];
    assign sw.home_fall = fall[home_pkg::SW_HOME];
    assign sw.fwd_lvl = lvl_ff[home_pkg::SW_FWD];
    assign sw.fwd_rise = rise[home_pkg::SW_FWD];
    assign sw.rev_lvl = lvl_ff[home_pkg::SW_REV];
    assign sw.rev_rise = rise[home_pkg::SW_REV];

    property p_home_rise_latency;
        @(posedge clk) disable iff (reset)
        // Three cycles after reset the older stage holds its cleared value, not the input.
        rise[home_pkg::SW_HOME] |-> $past(home_switch, 2) && ($past(reset, 3) || !$past(home_switch, 3));
    endproperty
    a_home_rise_latency: assert property (p_home_rise_latency)
        else $error("Home switch rise pulse does not match input history.");
endmodule
